// >>> hdl/six_pin_io_port.sv
module six_pin_io_port #(
  parameter bit ADC_VARIANT = 1'b1 // variant with adc and clock field
) (
  input wire logic clk, // system clock
  input wire logic rst, // power-on reset, sync, high
  input wire logic rstWarm, // pin or brown-out reset, sync, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic resetPinEnable, // pin three is external reset
  input wire logic crystalMode, // crystal oscillator on pins five, four
  input wire logic [gpio_pkg::NUM_PINS-1:0] pinIn, // pin levels, async
  output logic [gpio_pkg::NUM_PINS-1:0] pinOut, // output latch to pads
  output logic [gpio_pkg::NUM_PINS-1:0] pinOe, // pad driver enables
  output logic [gpio_pkg::NUM_PINS-1:0] pullupOn, // weak pull-up enables
  output logic [6:0] adcClockDivide, // adc clock divisor, 0 = rc
  output logic adcUseRcClock, // adc runs on rc clock
  output logic changeIrq, // change interrupt request
  output logic wakeRequest // wake from sleep
);
  import gpio_pkg::*;

  logic [5:0] pinSync1_r;
  logic [5:0] pinSync2_r;
  logic [5:0] latch_r;
  logic [5:0] dir_r;
  logic [3:0] analog_select_r;
  logic [2:0] adcClk_r;
  logic [5:0] pullup_r;
  logic [5:0] ioc_r;
  logic [5:0] lastRead_r;
  logic flag_r;
  logic pullOff_r;
  logic gie_r;
  logic [31:0] rdata_r;
  logic err_r;
  logic [5:0] analogPin;
  logic [5:0] portRead;
  logic [5:0] dirEff;
  logic [5:0] mismatch;
  logic [5:0] oscForce;
  logic setupPh;
  logic accessPh;
  logic wrEn;
  logic portAccess;
  logic [31:0] rdMux;
  logic mapped;

  // two-stage synchroniser; stage one is read only by stage two
  always_ff @(posedge clk)
  begin
    pinSync1_r <= pinIn;
    pinSync2_r <= pinSync1_r;
  end

  // analog pin map: channel three sits on pin four
  assign analogPin = {1'b0, analog_select_r[3], 1'b0, analog_select_r[2] & ADC_VARIANT,
    analog_select_r[1], analog_select_r[0]};
  assign oscForce = crystalMode ? OSC_PIN_MASK : 6'h00;
  assign dirEff = dir_r | PIN3_MASK | oscForce;

  // digital input path, masked by analog and reset-pin use
  always_comb
  begin
    portRead = pinSync2_r & ~analogPin;
    if (resetPinEnable)
    begin
      portRead[INPUT_ONLY_PIN] = 1'b0;
    end
  end

  // pads: analog select has no say over the driver
  assign pinOut = latch_r;
  assign pinOe = ~dirEff;

  // pull-ups: off for outputs, analog pins or global disable; pin three follows reset pin use only
  always_comb
  begin
    pullupOn = pullup_r & dirEff & ~analogPin & {6{~pullOff_r}};
    pullupOn[INPUT_ONLY_PIN] = resetPinEnable;
  end

  assign adcClockDivide = adcDivisor(adcClk_r);
  assign adcUseRcClock = (adcDivisor(adcClk_r) == 7'h00);

  // bus phases
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrEn = accessPh & pwrite & ~err_r;
  assign portAccess = accessPh & ~err_r & (paddr == OFF_PORT);
  assign pready = accessPh;
  assign prdata = rdata_r;
  assign pslverr = accessPh & err_r;

  // read mux with forced bits applied
  always_comb
  begin
    rdMux = 32'h0;
    mapped = 1'b1;
    case (paddr)
      OFF_PORT: rdMux[5:0] = portRead;
      OFF_DIR: rdMux[5:0] = dirEff;
      OFF_ANALOG_SELECT:
      begin
        rdMux[3:0] = {analog_select_r[3], analog_select_r[2] & ADC_VARIANT, analog_select_r[1:0]};
        rdMux[ADCCLK_LSB +: 3] = ADC_VARIANT ? adcClk_r : 3'h0;
      end
      OFF_PULLUP: rdMux[5:0] = (pullup_r & ~PIN3_MASK) | oscForce;
      OFF_IOC: rdMux[5:0] = ioc_r | oscForce;
      OFF_CTRL:
      begin
        rdMux[CTRL_FLAG_BIT] = flag_r;
        rdMux[CTRL_PULLOFF_BIT] = pullOff_r;
        rdMux[CTRL_GIE_BIT] = gie_r;
      end
      default: mapped = 1'b0;
    endcase
  end

  // read data and error captured in setup so they come from flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0;
      err_r <= 1'b0;
    end
    else if (setupPh)
    begin
      rdata_r <= pwrite ? 32'h0 : rdMux;
      err_r <= ~mapped;
    end
  end

  // output latch: keep mask bits take the pin level
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      latch_r <= LATCH_RST;
    end
    else if (wrEn & (paddr == OFF_PORT))
    begin
      latch_r <= (pwdata[5:0] & ~pwdata[KEEP_LSB +: 6])
        | (portRead & pwdata[KEEP_LSB +: 6]);
    end
  end

  // direction register
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      dir_r <= DIR_RST;
    end
    else if (wrEn & (paddr == OFF_DIR))
    begin
      dir_r <= pwdata[5:0];
    end
  end

  // analog select and adc clock field
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      analog_select_r <= ANALOG_SELECT_RST;
      adcClk_r <= ADCCLK_RST;
    end
    else if (wrEn & (paddr == OFF_ANALOG_SELECT))
    begin
      analog_select_r <= pwdata[3:0];
      adcClk_r <= ADC_VARIANT ? pwdata[ADCCLK_LSB +: 3] : ADCCLK_RST;
    end
  end

  // pull-up enables; pin three has no bit
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      pullup_r <= PULLUP_RST;
    end
    else if (wrEn & (paddr == OFF_PULLUP))
    begin
      pullup_r <= pwdata[5:0] & ~PIN3_MASK;
    end
  end

  // change enables, clear on every reset
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      ioc_r <= IOC_RST;
    end
    else if (wrEn & (paddr == OFF_IOC))
    begin
      ioc_r <= pwdata[5:0];
    end
  end

  // global controls
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      pullOff_r <= PULLOFF_RST;
      gie_r <= GIE_RST;
    end
    else if (wrEn & (paddr == OFF_CTRL))
    begin
      pullOff_r <= pwdata[CTRL_PULLOFF_BIT];
      gie_r <= pwdata[CTRL_GIE_BIT];
    end
  end

  // last-read latch; only power-on clears it so warm resets re-flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lastRead_r <= LATCH_RST;
    end
    else if (portAccess)
    begin
      lastRead_r <= portRead;
    end
  end

  // enabled, digital pins that differ from the last read
  assign mismatch = ioc_r & ~analogPin & (portRead ^ lastRead_r);

  // flag: set wins over the write-one clear; skipped while the port is
  // accessed, a miss the hardware is allowed
  always_ff @(posedge clk)
  begin
    if (rst | rstWarm)
    begin
      flag_r <= 1'b0;
    end
    else if ((|mismatch) & ~portAccess)
    begin
      flag_r <= 1'b1;
    end
    else if (wrEn & (paddr == OFF_CTRL) & pwdata[CTRL_FLAG_BIT])
    begin
      flag_r <= 1'b0;
    end
  end

  assign wakeRequest = flag_r;
  assign changeIrq = flag_r & gie_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst | rstWarm);

  sequence portReadDone;
    accessPh & ~pwrite & ~err_r & (paddr == OFF_PORT);
  endsequence

  // software clearing the change flag by writing one to its bit
  sequence flagClearWrite;
    wrEn & (paddr == OFF_CTRL) & pwdata[CTRL_FLAG_BIT];
  endsequence

  // a port write whose keep mask is empty, so no pin level leaks in
  sequence portPlainWrite;
    wrEn & (paddr == OFF_PORT) & (pwdata[KEEP_LSB +: 6] == 6'h00);
  endsequence

  // a direction write that lands at the end of this cycle
  sequence dirWrite;
    wrEn & (paddr == OFF_DIR);
  endsequence

  pin3_never_driven_a: assert property (!pinOe[INPUT_ONLY_PIN])
    else $error("pin three driven");
  out_follows_dir_a: assert property (pinOe == ~dirEff && pinOut == latch_r)
    else $error("driver does not follow direction");
  dir3_reads_one_a: assert property (setupPh && !pwrite && paddr == OFF_DIR
    |=> prdata[INPUT_ONLY_PIN])
    else $error("pin three direction read zero");
  analog_reads_zero_a: assert property (setupPh && !pwrite && paddr == OFF_PORT
    |=> (prdata[5:0] & $past(analogPin)) == 6'h00)
    else $error("analog pin read nonzero");
  pullup_out_off_a: assert property ((pullupOn & ~dirEff & ~PIN3_MASK) == 6'h00)
    else $error("pull-up on an output");
  pin3_pullup_a: assert property (pullupOn[INPUT_ONLY_PIN] == resetPinEnable)
    else $error("pin three pull-up wrong");
  flag_sets_a: assert property ((|mismatch) && !portAccess |=> flag_r)
    else $error("mismatch did not set flag");
  read_ends_mismatch_a: assert property (portReadDone ##1 $stable(pinSync2_r)
    && $stable(analog_select_r) && $stable(resetPinEnable) |-> mismatch == 6'h00)
    else $error("read did not end mismatch");
  crystal_force_a: assert property (crystalMode && setupPh && !pwrite
    && paddr == OFF_IOC |=> prdata[5:4] == 2'b11)
    else $error("crystal bits not forced");
  irq_gated_a: assert property (changeIrq |-> gie_r && flag_r)
    else $error("interrupt without enable");

  // driver enables must follow the last direction write
  dir_drives_a: assert property (dirWrite |=>
    pinOe == ~($past(pwdata[5:0]) | PIN3_MASK | oscForce))
    else $error("drivers differ from direction written");

  // a plain port write puts exactly the bus bits on the latch
  latch_plain_write_a: assert property (portPlainWrite |=>
    pinOut == $past(pwdata[5:0]))
    else $error("latch differs from port write");

  // pin three reads low while it serves as the reset pin
  reset_pin_reads_a: assert property (setupPh && !pwrite && paddr == OFF_PORT
    && resetPinEnable |=> !prdata[INPUT_ONLY_PIN])
    else $error("pin three read high as reset pin");

  // analog writes must leave drivers and latch untouched
  analog_drive_a: assert property (wrEn && paddr == OFF_ANALOG_SELECT
    |=> $stable(pinOe) && $stable(pinOut))
    else $error("analog write changed the drivers");

  // an analog pin never gets a pull-up
  analog_pullup_off_a: assert property ((pullupOn & analogPin) == 6'h00)
    else $error("pull-up on an analog pin");

  // channel three masks pin four, not pin three
  analog_map_a: assert property (analog_select_r[3] |-> !portRead[4])
    else $error("channel three does not mask pin four");

  // the two codes ending in ones select the rc clock, no others
  rc_clock_a: assert property (adcUseRcClock == (adcClk_r[1:0] == 2'h3))
    else $error("rc clock choice wrong");

  // slowest divider code
  div64_a: assert property (adcClk_r == ADCS_DIV64 |-> adcClockDivide == 7'h40)
    else $error("divide by sixty-four wrong");

  // the global control overrides every software pull-up
  pullup_global_a: assert property (pullOff_r |-> (pullupOn & ~PIN3_MASK) == 6'h00)
    else $error("pull-up on while globally off");

  // change enables come out of power-on reset cleared
  change_en_por_a: assert property ($fell(rst) |-> ioc_r == 6'h00)
    else $error("change enables set after power-on");

  // only a clear write or a reset takes the flag down
  flag_held_a: assert property (flag_r && !(wrEn && paddr == OFF_CTRL
    && pwdata[CTRL_FLAG_BIT]) |=> flag_r)
    else $error("flag dropped without a clear");

  // with the mismatch ended a clear write does take the flag down
  flag_clear_a: assert property ((flag_r && mismatch == 6'h00) ##0 flagClearWrite
    |=> !flag_r)
    else $error("flag survived its clear");

  // warm resets leave the last-read copy alone; this one has its own
  // disable since the default one would hide exactly those cycles
  lastread_warm_a: assert property (@(posedge clk) disable iff (rst)
    rstWarm && !portAccess |=> lastRead_r == $past(lastRead_r))
    else $error("last-read copy lost in warm reset");

  // pins five and four never driven while the crystal owns them
  crystal_inputs_a: assert property (crystalMode |-> (pinOe & OSC_PIN_MASK) == 6'h00)
    else $error("crystal pin driven");

  // pin levels reach the logic exactly two cycles late, never sooner
  sync_delay_a: assert property (pinSync2_r == $past(pinIn, 2))
    else $error("synchroniser depth wrong");
endmodule : six_pin_io_port

// >>> include/gpio_pkg.sv
// Functional notes
// - six pins, pin three input only
// - direction one is input, zero drives latch
// - pin three direction always reads one
// - port read gives pins, write is read-modify-write
// - reset pin enabled makes pin three read zero
// - analog pins read zero, never raise change
// - analog select leaves output driving untouched
// - analog select kills input, pull-up, change detect
// - analog bits map pins; bit two variant only
// - adc clock select field encodes divisors
// - per-pin pull-up enables, except pin three
// - output direction forces pull-up off
// - global pull-up control gates all but pin three; off at power-on
// - pin three pull-up follows reset pin use
// - per-pin change enables, cleared at power-on
// - enabled pins compared with last read, ORed
// - change flag can wake from sleep
// - mismatch keeps setting flag until port accessed
// - last-read latch survives warm resets
// - change during port access may be missed
// - crystal modes force bits five, four to one
package gpio_pkg;
  localparam int NUM_PINS = 6;
  localparam int INPUT_ONLY_PIN = 3;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_PORT = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_ANALOG_SELECT = 8'h08;
  localparam logic [7:0] OFF_PULLUP = 8'h0c;
  localparam logic [7:0] OFF_IOC = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  // values after reset
  localparam logic [5:0] DIR_RST = 6'h3f;
  localparam logic [3:0] ANALOG_SELECT_RST = 4'hf;
  localparam logic [2:0] ADCCLK_RST = 3'h0;
  localparam logic [5:0] PULLUP_RST = 6'h37;
  localparam logic [5:0] IOC_RST = 6'h00;
  localparam logic [5:0] LATCH_RST = 6'h00;
  localparam logic PULLOFF_RST = 1'b1;
  localparam logic GIE_RST = 1'b0;
  // field positions
  localparam int ADCCLK_LSB = 4;
  localparam int KEEP_LSB = 8;
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_PULLOFF_BIT = 1;
  localparam int CTRL_GIE_BIT = 2;
  localparam logic [5:0] OSC_PIN_MASK = 6'h30;
  localparam logic [5:0] PIN3_MASK = 6'h08;
  // adc clock select codes
  localparam logic [2:0] ADCS_DIV2 = 3'h0;
  localparam logic [2:0] ADCS_DIV8 = 3'h1;
  localparam logic [2:0] ADCS_DIV32 = 3'h2;
  localparam logic [2:0] ADCS_DIV4 = 3'h4;
  localparam logic [2:0] ADCS_DIV16 = 3'h5;
  localparam logic [2:0] ADCS_DIV64 = 3'h6;

  // divisor of the system clock; zero means the dedicated rc clock
  function automatic logic [6:0] adcDivisor(input logic [2:0] sel);
    logic [6:0] d;
    d = 7'h00;
    case (sel)
      ADCS_DIV2: d = 7'h02;
      ADCS_DIV8: d = 7'h08;
      ADCS_DIV32: d = 7'h20;
      ADCS_DIV4: d = 7'h04;
      ADCS_DIV16: d = 7'h10;
      ADCS_DIV64: d = 7'h40;
      default: d = 7'h00;
    endcase
    return d;
  endfunction : adcDivisor
endpackage : gpio_pkg

// >>> tb/pad_model.sv
module pad_model
  import gpio_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic [gpio_pkg::NUM_PINS-1:0] pinOut, // latch to pads
  input wire logic [gpio_pkg::NUM_PINS-1:0] pinOe, // driver enables
  input wire logic [gpio_pkg::NUM_PINS-1:0] pullupOn, // weak pull-ups
  input wire logic [gpio_pkg::NUM_PINS-1:0] extOe, // far side drives
  input wire logic [gpio_pkg::NUM_PINS-1:0] extVal, // far side level
  output logic [gpio_pkg::NUM_PINS-1:0] pinIn // resolved pad level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt = 1'b0;
  // a floating pad wanders so a stale value never reads back by luck
  always @(posedge clk) flt <= ~flt;
  // device driver wins, then far side, then pull-up
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : extOe[i] ? extVal[i] : pullupOn[i] ? 1'b1 : flt;
  end
endmodule : pad_model

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  logic clk = 0, rst = 1, rstWarm = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, resetPinEnable = 0, crystalMode = 0;
  logic [NUM_PINS-1:0] pinIn, pinOut, pinOe, pullupOn;
  logic [NUM_PINS-1:0] extOe = 6'h3f, extVal = 6'h00;
  logic [6:0] adcClockDivide;
  logic adcUseRcClock, changeIrq, wakeRequest;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [6:0] divTab [8] = '{7'h02, 7'h08, 7'h20, 7'h00, 7'h04, 7'h10, 7'h40, 7'h00};
  logic [31:0] rstTab [5] = '{32'h3f, 32'h0f, 32'h37, 32'h00, 32'h02};
  logic [7:0] xtalAddr [3] = '{OFF_DIR, OFF_PULLUP, OFF_IOC};
  always #50 clk = ~clk;
  six_pin_io_port dut (.clk(clk), .rst(rst), .rstWarm(rstWarm), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resetPinEnable(resetPinEnable),
    .crystalMode(crystalMode), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullupOn(pullupOn), .adcClockDivide(adcClockDivide), .adcUseRcClock(adcUseRcClock),
    .changeIrq(changeIrq), .wakeRequest(wakeRequest));
  pad_model pads (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
    .extOe(extOe), .extVal(extVal), .pinIn(pinIn));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // a hang ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      complete_run();
    end
  end
  // one apb transfer; data and error taken at the ready edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // pins are sampled through two flops, so let a change settle
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      bus(0, OFF_DIR + 8'(4 * i), 0);
      chk("reset value", rstTab[i], rdat);
    end
    bus(0, 8'h18, 0);
    chk("unmapped err", 1, rerr);
    $display("test reset done");
    bus(1, OFF_ANALOG_SELECT, 0);
    bus(1, OFF_DIR, 0);
    bus(0, OFF_DIR, 0);
    chk("dir pin3", 32'h08, rdat);
    chk("drivers", 32'h37, pinOe);
    bus(1, OFF_PORT, 32'h15);
    extVal <= 6'h08;
    settle();
    bus(0, OFF_PORT, 0);
    chk("port read", 32'h1d, rdat);
    resetPinEnable <= 1'b1;
    bus(0, OFF_PORT, 0);
    chk("pin3 as reset", 32'h15, rdat);
    resetPinEnable <= 1'b0;
    bus(1, OFF_PORT, 32'h3f00);
    chk("rmw latch", 32'h1d, pinOut);
    bus(1, OFF_ANALOG_SELECT, 32'h09);
    bus(0, OFF_PORT, 0);
    chk("analog read", 32'h0c, rdat);
    chk("analog drive", 32'h1d, pinOut);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, OFF_ANALOG_SELECT, 32'(i << 4));
      chk("adc divide", divTab[i], adcClockDivide);
      chk("adc rc", i % 4 == 3, adcUseRcClock);
    end
    $display("test port done");
    bus(1, OFF_ANALOG_SELECT, 0);
    bus(1, OFF_DIR, 32'h3f);
    chk("pullup global", 0, pullupOn);
    bus(1, OFF_CTRL, 0);
    chk("pullup on", 32'h37, pullupOn);
    bus(1, OFF_DIR, 32'h0f);
    chk("pullup output", 32'h07, pullupOn);
    bus(1, OFF_ANALOG_SELECT, 32'h01);
    chk("pullup analog", 32'h06, pullupOn);
    resetPinEnable <= 1'b1;
    @(posedge clk);
    chk("pullup pin3", 32'h0e, pullupOn);
    resetPinEnable <= 1'b0;
    bus(1, OFF_ANALOG_SELECT, 0);
    bus(1, OFF_DIR, 32'h3f);
    $display("test pullup done");
    bus(1, OFF_IOC, 32'h3f);
    bus(1, OFF_CTRL, 32'h04);
    bus(0, OFF_PORT, 0);
    bus(1, OFF_CTRL, 32'h05);
    bus(0, OFF_CTRL, 0);
    chk("flag idle", 32'h04, rdat);
    extVal <= 6'h0c;
    settle();
    bus(0, OFF_CTRL, 0);
    chk("flag set", 32'h05, rdat);
    chk("irq", 1, changeIrq);
    chk("wake", 1, wakeRequest);
    bus(1, OFF_CTRL, 32'h05);
    bus(0, OFF_CTRL, 0);
    chk("flag held", 32'h05, rdat);
    bus(0, OFF_PORT, 0);
    bus(1, OFF_CTRL, 32'h05);
    bus(0, OFF_CTRL, 0);
    chk("flag cleared", 32'h04, rdat);
    extVal <= 6'h08;
    settle();
    rstWarm <= 1'b1;
    repeat (2) @(posedge clk);
    rstWarm <= 1'b0;
    bus(1, OFF_ANALOG_SELECT, 0);
    bus(1, OFF_IOC, 32'h3f);
    bus(0, OFF_CTRL, 0);
    chk("flag after warm", 32'h03, rdat);
    chk("irq gated", 0, changeIrq);
    chk("wake after warm", 1, wakeRequest);
    chk("drivers after warm", 0, pinOe);
    bus(0, OFF_PORT, 0);
    bus(1, OFF_CTRL, 32'h03);
    bus(1, OFF_ANALOG_SELECT, 32'h04);
    extVal <= 6'h0c;
    settle();
    bus(0, OFF_CTRL, 0);
    chk("analog no flag", 32'h02, rdat);
    $display("test change done");
    crystalMode <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      bus(1, xtalAddr[i], 0);
      bus(0, xtalAddr[i], 0);
      chk("crystal bits", 32'h30, rdat & 32'h30);
    end
    $display("test crystal done");
    complete_run();
  end
endmodule : tb
